// *** hw/mapper_pkg.sv ***
// package for the emulated opcode to macro address mapper
// assumes one 40 MHz clock and an active-low asynchronous reset
//
// What this block does
// - hardware maps each valid opcode to macro entry
// - opcodes 50H-FFH: clear low byte, shift right four
// - base-relative groups of four share one address
// - indexed nibble 0..F maps 0030 to 03F0
// - original instruction kept for shared macros
// - opcodes 48, 49, 4F map to 0480, 0490, 04F0
// - immediate 4A nibble 1..B maps 0050 to 02D0
// - I/O FFFE status, FFFF receive, 7FFF transmit
// - console output, input and status alias the UART I/O addresses
// - optional I/O commands flagged as unsupported
// - byte operand in low eight bits
// - long words use even/odd pairs, even high
// - byte size only for byte instructions
// - fixed point is two's complement, sign msb
package mapper_pkg;
  // ---------------------------------------------------------------
  // mapping constants
  // ---------------------------------------------------------------
  localparam logic [7:0] SHIFT_RULE_FIRST = 8'h50;
  localparam logic [7:0] BASE_REL_LAST = 8'h3f;
  localparam logic [7:0] INDEXED_FIRST = 8'h40;
  localparam logic [7:0] INDEXED_LAST = 8'h43;
  localparam logic [7:0] IO_TRANSFER_OP = 8'h48;
  localparam logic [7:0] VECTORED_IO_OP = 8'h49;
  localparam logic [7:0] IMMEDIATE_OP = 8'h4a;
  localparam logic [7:0] NATIVE_ESCAPE_OP = 8'h4f;
  localparam logic [15:0] SELECTOR_STEP = 16'h0040;
  localparam logic [15:0] BASE_REL_OFFSET = 16'h0020;
  localparam logic [15:0] INDEXED_OFFSET = 16'h0030;
  localparam logic [15:0] IMMEDIATE_OFFSET = 16'h0010;
  localparam logic [3:0] IMMEDIATE_SEL_FIRST = 4'h1;
  localparam logic [3:0] IMMEDIATE_SEL_LAST = 4'hb;
  localparam logic [15:0] MACRO_ADDR_RESET = 16'h0000;
  // ---------------------------------------------------------------
  // I/O map and console commands
  // ---------------------------------------------------------------
  localparam logic [15:0] UART_TRANSMIT_BUFFER = 16'h7fff;
  localparam logic [15:0] RISC_STATUS_WORD = 16'hfffe;
  localparam logic [15:0] UART_RECEIVE_BUFFER = 16'hffff;
  localparam logic [15:0] CONSOLE_OUTPUT = 16'h4000;
  localparam logic [15:0] CONSOLE_CLEAR = 16'h4001;
  localparam logic [15:0] CONSOLE_INPUT = 16'hc000;
  localparam logic [15:0] CONSOLE_STATUS_READ = 16'hc001;
  localparam logic [15:0] DISCRETE_OUTPUT_CMD = 16'h2008;
  localparam logic [15:0] RESET_DISCRETE_CMD = 16'h200a;
  localparam logic [15:0] PROTECT_ENABLE_CMD = 16'h4003;
  localparam logic [7:0] PROTECT_RAM_LOAD_HI = 8'h50;
  localparam logic [7:0] PROTECT_RAM_READ_HI = 8'hd0;
  localparam logic [15:0] INT_CODE1_READ = 16'ha001;
  localparam logic [15:0] INT_CODE2_READ = 16'ha002;
  localparam logic [15:0] DISCRETE_OUT_READ = 16'ha008;
  localparam logic [15:0] DISCRETE_IN_READ = 16'ha009;
  localparam logic [15:0] PROGRAMMED_OUTPUT_TEST = 16'ha00b;
  localparam logic [15:0] TRANSMIT_RESET = 16'h0000;
  // ---------------------------------------------------------------
  // register file and types
  // ---------------------------------------------------------------
  localparam int NUM_GEN_REGS = 20;
  localparam logic [7:0] BYTE_MASK = 8'hff;
  typedef enum logic [1:0] {SIZE_BYTE = 2'b00, SIZE_WORD = 2'b01, SIZE_LONG = 2'b11} op_size_t;
  typedef enum logic [2:0] {
    IO_NONE = 3'h0, IO_READ_STATUS = 3'h1, IO_READ_RX = 3'h3, IO_WRITE_TX = 3'h2,
    IO_NOP = 3'h6, IO_UNSUPPORTED = 3'h7, IO_EXTERNAL = 3'h5
  } io_action_t;
  typedef struct packed {
    logic valid;
    logic invalid;
    logic [15:0] addr;
  } macro_req_t;
endpackage

// *** hw/opcode_macro_address_mapper.sv ***
// opcode to macro entry mapper, I/O command decode, operand registers
// assumes fetch sequencer presents one instruction word per valid pulse
`timescale 1ns/1ps
module opcode_macro_address_mapper
  import mapper_pkg::*;
#(
  parameter int NUM_REGS = NUM_GEN_REGS
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // instruction from fetch sequencer
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  // macro entry answer
  output macro_req_t macro_o,
  output logic [15:0] fetch_original_instruction_o,
  // I/O command from io_transfer_instruction macro
  input wire logic io_cmd_valid_i,
  input wire logic [15:0] io_cmd_i,
  input wire logic [15:0] named_target_register_i,
  input wire logic [15:0] status_word_i,
  input wire logic [15:0] rx_data_i,
  output io_action_t io_action_o,
  output logic [15:0] io_read_data_o,
  output logic [15:0] uart_transmit_buffer_o,
  output logic tx_load_o,
  // general register file
  input wire logic reg_wr_i,
  input wire logic [4:0] reg_wr_idx_i,
  input wire logic [31:0] reg_wr_data_i,
  input wire op_size_t size_i,
  input wire logic byte_instr_i,
  input wire logic [4:0] reg_rd_idx_i,
  output logic [31:0] operand_o,
  output logic operand_negative_o,
  output logic size_error_o
);
  // elaboration check on the register count
  if (NUM_REGS < 2 || NUM_REGS > 32 || NUM_REGS % 2 != 0)
  begin : g_bad_num_regs
    $error("NUM_REGS must be even and 2..32");
  end

  // ---------------------------------------------------------------
  // macro address mapping
  // ---------------------------------------------------------------
  function automatic logic [15:0] sel_addr(input logic [3:0] sel, input logic [15:0] offs);
    sel_addr = 16'({12'h000, sel} * SELECTOR_STEP) + offs;
  endfunction

  macro_req_t next_macro;
  logic [15:0] orig_instr, next_orig_instr;
  logic [7:0] op;

  // combinational mapping of the opcode byte
  always_comb
  begin
    op = instr_i[15:8];
    next_macro = '{valid: instr_valid_i, invalid: 1'b0, addr: macro_o.addr};
    next_orig_instr = instr_valid_i ? instr_i : orig_instr;
    if (instr_valid_i)
    begin
      if (op >= SHIFT_RULE_FIRST)
        next_macro.addr = 16'({instr_i[15:8], 8'h00} >> 4);
      else if (op <= BASE_REL_LAST)
        next_macro.addr = sel_addr(op[5:2], BASE_REL_OFFSET);
      else if (op >= INDEXED_FIRST && op <= INDEXED_LAST)
        next_macro.addr = sel_addr(instr_i[7:4], INDEXED_OFFSET);
      else if (op == IO_TRANSFER_OP || op == VECTORED_IO_OP || op == NATIVE_ESCAPE_OP)
        next_macro.addr = {4'h0, op, 4'h0};
      else if (op == IMMEDIATE_OP && instr_i[3:0] >= IMMEDIATE_SEL_FIRST
               && instr_i[3:0] <= IMMEDIATE_SEL_LAST)
        next_macro.addr = sel_addr(instr_i[3:0], IMMEDIATE_OFFSET);
      else
        next_macro.invalid = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      macro_o <= '{valid: 1'b0, invalid: 1'b0, addr: MACRO_ADDR_RESET};
      orig_instr <= 16'h0000;
    end
    else
    begin
      macro_o <= next_macro;
      orig_instr <= next_orig_instr;
    end
  end
  assign fetch_original_instruction_o = orig_instr;

  // ---------------------------------------------------------------
  // I/O command decode
  // ---------------------------------------------------------------
  function automatic io_action_t io_decode(input logic [15:0] cmd);
    io_decode = IO_EXTERNAL;
    if (cmd == RISC_STATUS_WORD || cmd == CONSOLE_STATUS_READ)
      io_decode = IO_READ_STATUS;
    else if (cmd == UART_RECEIVE_BUFFER || cmd == CONSOLE_INPUT)
      io_decode = IO_READ_RX;
    else if (cmd == UART_TRANSMIT_BUFFER || cmd == CONSOLE_OUTPUT)
      io_decode = IO_WRITE_TX;
    else if (cmd == CONSOLE_CLEAR)
      io_decode = IO_NOP;
    else if (cmd == DISCRETE_OUTPUT_CMD || cmd == RESET_DISCRETE_CMD
             || cmd == PROTECT_ENABLE_CMD || cmd[15:8] == PROTECT_RAM_LOAD_HI
             || cmd[15:8] == PROTECT_RAM_READ_HI || cmd == INT_CODE1_READ
             || cmd == INT_CODE2_READ || cmd == DISCRETE_OUT_READ
             || cmd == DISCRETE_IN_READ || cmd == PROGRAMMED_OUTPUT_TEST)
      io_decode = IO_UNSUPPORTED;
  endfunction

  io_action_t next_io_action;
  logic [15:0] next_io_read_data, next_tx;
  logic next_tx_load;

  // next values of the I/O answer
  always_comb
  begin
    next_io_action = io_cmd_valid_i ? io_decode(io_cmd_i) : IO_NONE;
    next_io_read_data = io_read_data_o;
    next_tx = uart_transmit_buffer_o;
    next_tx_load = 1'b0;
    unique case (next_io_action)
      IO_READ_STATUS: next_io_read_data = status_word_i;
      IO_READ_RX: next_io_read_data = rx_data_i;
      IO_WRITE_TX:
      begin
        next_tx = named_target_register_i;
        next_tx_load = 1'b1;
      end
      IO_NONE, IO_NOP, IO_UNSUPPORTED, IO_EXTERNAL: next_io_read_data = io_read_data_o;
    endcase
  end

  // register the I/O answer
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      io_action_o <= IO_NONE;
      io_read_data_o <= 16'h0000;
      uart_transmit_buffer_o <= TRANSMIT_RESET;
      tx_load_o <= 1'b0;
    end
    else
    begin
      io_action_o <= next_io_action;
      io_read_data_o <= next_io_read_data;
      uart_transmit_buffer_o <= next_tx;
      tx_load_o <= next_tx_load;
    end
  end

  // ---------------------------------------------------------------
  // general registers and operand read
  // ---------------------------------------------------------------
  logic [15:0] regs [NUM_REGS];
  logic [15:0] next_regs [NUM_REGS];
  logic [4:0] even_wr, even_rd;
  logic [31:0] next_operand;
  logic next_negative, next_size_error;

  assign even_wr = {reg_wr_idx_i[4:1], 1'b0};
  assign even_rd = {reg_rd_idx_i[4:1], 1'b0};

  // next register contents and operand
  always_comb
  begin
    for (int i = 0; i < NUM_REGS; i++)
      next_regs[i] = regs[i];
    // byte size only for byte instructions
    next_size_error = ((size_i == SIZE_BYTE) != byte_instr_i) || size_i == 2'b10;
    if (reg_wr_i && !next_size_error && int'(reg_wr_idx_i) < NUM_REGS)
    begin
      unique case (size_i)
        // byte goes to low eight bits
        SIZE_BYTE: next_regs[reg_wr_idx_i][7:0] = reg_wr_data_i[7:0];
        SIZE_WORD: next_regs[reg_wr_idx_i] = reg_wr_data_i[15:0];
        SIZE_LONG:
        begin
          next_regs[even_wr] = reg_wr_data_i[31:16];
          next_regs[5'(even_wr + 5'd1)] = reg_wr_data_i[15:0];
        end
        default: next_size_error = 1'b1;
      endcase
    end
    next_operand = 32'h0000_0000;
    next_negative = 1'b0;
    if (int'(reg_rd_idx_i) < NUM_REGS)
    begin
      unique case (size_i)
        SIZE_BYTE: next_operand = {24'h000000, regs[reg_rd_idx_i][7:0] & BYTE_MASK};
        SIZE_WORD: next_operand = {16'h0000, regs[reg_rd_idx_i]};
        SIZE_LONG: next_operand = {regs[even_rd], regs[5'(even_rd + 5'd1)]};
        default: next_operand = 32'h0000_0000;
      endcase
      next_negative = size_i == SIZE_LONG ? next_operand[31]
                    : size_i == SIZE_WORD ? next_operand[15] : next_operand[7];
    end
  end

  // register file and operand flops
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs[i] <= 16'h0000;
      operand_o <= 32'h0000_0000;
      operand_negative_o <= 1'b0;
      size_error_o <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs[i] <= next_regs[i];
      operand_o <= next_operand;
      operand_negative_o <= next_negative;
      size_error_o <= next_size_error;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_shift_rule;
    @(posedge clk_i) disable iff (!nrst_i)
    instr_valid_i && instr_i[15:8] >= 8'h50 |=> macro_o.valid && !macro_o.invalid
      && macro_o.addr == {4'h0, $past(instr_i[15:8]), 4'h0};
  endproperty
  a_shift_rule: assert property (p_shift_rule) else $error("upper opcode address wrong");
  property p_base_rel;
    @(posedge clk_i) disable iff (!nrst_i)
    instr_valid_i && instr_i[15:8] <= 8'h3f |=> macro_o.addr[5:0] == 6'h20
      && macro_o.addr[9:6] == $past(instr_i[13:10]);
  endproperty
  a_base_rel: assert property (p_base_rel) else $error("base relative address wrong");
  property p_indexed;
    @(posedge clk_i) disable iff (!nrst_i)
    instr_valid_i && instr_i[15:10] == 6'h10 |=> macro_o.addr ==
      {6'h00, $past(instr_i[7:4]), 6'h30};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");
  property p_original;
    @(posedge clk_i) disable iff (!nrst_i)
    instr_valid_i ##1 (!instr_valid_i) [*2]
      |-> fetch_original_instruction_o == $past(instr_i, 2);
  endproperty
  a_original: assert property (p_original) else $error("original word lost");
  property p_escape;
    @(posedge clk_i) disable iff (!nrst_i)
    instr_valid_i && instr_i[15:8] == 8'h4f |=> macro_o.addr == 16'h04f0;
  endproperty
  a_escape: assert property (p_escape) else $error("escape address wrong");
  property p_immediate;
    @(posedge clk_i) disable iff (!nrst_i)
    instr_valid_i && instr_i[15:8] == 8'h4a && instr_i[3:0] == 4'hb |=> macro_o.addr == 16'h02d0;
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate address wrong");
  property p_console_out;
    @(posedge clk_i) disable iff (!nrst_i)
    io_cmd_valid_i && io_cmd_i == 16'h4000 |=> tx_load_o
      && uart_transmit_buffer_o == $past(named_target_register_i);
  endproperty
  a_console_out: assert property (p_console_out) else $error("console output not sent");
  property p_status_read;
    @(posedge clk_i) disable iff (!nrst_i)
    io_cmd_valid_i && io_cmd_i == 16'hfffe |=> io_read_data_o == $past(status_word_i);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");
  property p_unsupported;
    @(posedge clk_i) disable iff (!nrst_i)
    io_cmd_valid_i && io_cmd_i == 16'ha00b |=> io_action_o == IO_UNSUPPORTED && !tx_load_o;
  endproperty
  a_unsupported: assert property (p_unsupported) else $error("optional command taken");
  property p_invalid;
    @(posedge clk_i) disable iff (!nrst_i)
    instr_valid_i && instr_i[15:8] inside {[8'h44:8'h47], [8'h4b:8'h4e]} |=> macro_o.valid
      && macro_o.invalid && $stable(macro_o.addr);
  endproperty
  a_invalid: assert property (p_invalid) else $error("unlisted opcode not flagged");
endmodule

// *** test/fetch_sequencer_model.sv ***
// fetch sequencer model: hands instruction words to the mapper
// assumes the bench queues words and sets slow for random spacing
`timescale 1ns/1ps
module fetch_sequencer_model
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // instruction towards the mapper
  output logic instr_valid_o,
  output logic [15:0] instr_o
);
  logic [15:0] words[$];
  logic slow = 1'b0;
  int gap = 0;
  // one word per cycle, or gapped when slow; idle word keeps moving
  initial
  begin
    instr_valid_o = 1'b0;
    instr_o = 16'h0000;
    forever
    begin
      @(posedge clk_i);
      #2;
      if (nrst_i && words.size() > 0 && gap == 0)
      begin
        instr_valid_o = 1'b1;
        instr_o = words.pop_front();
        gap = slow ? $urandom_range(0, 2) : 0;
      end
      else
      begin
        instr_valid_o = 1'b0;
        instr_o = ~instr_o;
        if (gap > 0) gap--;
      end
    end
  end
endmodule

// *** test/test_opcode_macro_address_mapper.sv ***
// self-checking bench for the opcode to macro entry mapper
// assumes one 40 MHz clock; expectations queued, checked on negedge
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module test_opcode_macro_address_mapper;
  import mapper_pkg::*;
  logic clk_i, nrst_i, instr_valid_i, io_cmd_valid_i, reg_wr_i, byte_instr_i;
  logic [15:0] instr_i, io_cmd_i, named_target_register_i, status_word_i, rx_data_i;
  logic [4:0] reg_wr_idx_i, reg_rd_idx_i;
  logic [31:0] reg_wr_data_i, operand_o;
  op_size_t size_i;
  macro_req_t macro_o;
  io_action_t io_action_o;
  logic [15:0] fetch_original_instruction_o, io_read_data_o, uart_transmit_buffer_o;
  logic tx_load_o, operand_negative_o, size_error_o;
  logic [32:0] mq[$];
  logic [34:0] iq[$];
  logic [32:0] m;
  logic [34:0] q;
  logic [33:0] rq[$];
  logic [33:0] r;
  logic rd_req = 1'b0, rd_due = 1'b0;
  logic [15:0] last_addr = 16'h0000, last_rd = 16'h0000, last_tx = 16'h0000;
  int n_fail = 0, total_checks = 0;
  logic [15:0] cmds[] = '{16'h7fff, 16'hfffe, 16'hffff, 16'h4000, 16'hc000, 16'hc001,
    16'h4001, 16'h2008, 16'h200a, 16'h4003, 16'h5012, 16'ha001, 16'ha002, 16'ha008,
    16'ha009, 16'ha00b, 16'hd0ff, 16'h1234};

  fetch_sequencer_model fsm (.clk_i(clk_i), .nrst_i(nrst_i), .instr_valid_o(instr_valid_i),
    .instr_o(instr_i));
  opcode_macro_address_mapper uut (.clk_i(clk_i), .nrst_i(nrst_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .macro_o(macro_o),
    .fetch_original_instruction_o(fetch_original_instruction_o),
    .io_cmd_valid_i(io_cmd_valid_i), .io_cmd_i(io_cmd_i),
    .named_target_register_i(named_target_register_i), .status_word_i(status_word_i),
    .rx_data_i(rx_data_i), .io_action_o(io_action_o), .io_read_data_o(io_read_data_o),
    .uart_transmit_buffer_o(uart_transmit_buffer_o), .tx_load_o(tx_load_o),
    .reg_wr_i(reg_wr_i), .reg_wr_idx_i(reg_wr_idx_i), .reg_wr_data_i(reg_wr_data_i),
    .size_i(size_i), .byte_instr_i(byte_instr_i), .reg_rd_idx_i(reg_rd_idx_i),
    .operand_o(operand_o), .operand_negative_o(operand_negative_o),
    .size_error_o(size_error_o));

  // ---------------------------------------------------------------
  // expected values
  // ---------------------------------------------------------------
  // {invalid, entry address} for one instruction word
  function logic [16:0] map_exp(input logic [15:0] w);
    if (w[15:8] <= 8'h3f) return {1'b0, 6'h00, w[13:10], 6'h20};
    if (w[15:8] <= 8'h43) return {1'b0, 6'h00, w[7:4], 6'h30};
    if (w[15:8] == 8'h4a && w[3:0] >= 4'h1 && w[3:0] <= 4'hb)
      return {1'b0, 6'h00, w[3:0], 6'h10};
    if (w[15:8] >= 8'h50 || w[15:8] inside {8'h48, 8'h49, 8'h4f})
      return {1'b0, 4'h0, w[15:8], 4'h0};
    return {1'b1, last_addr};
  endfunction
  // decoded action for one I/O command word
  function io_action_t io_exp(input logic [15:0] c);
    case (c)
      16'h7fff, 16'h4000: return IO_WRITE_TX;
      16'hfffe, 16'hc001: return IO_READ_STATUS;
      16'hffff, 16'hc000: return IO_READ_RX;
      16'h4001: return IO_NOP;
      16'h2008, 16'h200a, 16'h4003, 16'ha001, 16'ha002, 16'ha008, 16'ha009, 16'ha00b:
        return IO_UNSUPPORTED;
      default: return (c[15:8] inside {8'h50, 8'hd0}) ? IO_UNSUPPORTED : IO_EXTERNAL;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  // queue one word at the sequencer and note its answer
  task automatic send(input logic [15:0] w);
    logic [16:0] e;
    e = map_exp(w);
    if (!e[16]) last_addr = e[15:0];
    fsm.words.push_back(w);
    mq.push_back({e, w});
  endtask
  // one I/O command with fresh source data; valid left high
  task automatic io(input logic [15:0] c);
    io_action_t a;
    a = io_exp(c);
    io_cmd_i = c;
    status_word_i = 16'($urandom);
    rx_data_i = 16'($urandom);
    named_target_register_i = 16'($urandom);
    io_cmd_valid_i = 1'b1;
    if (a == IO_READ_STATUS) last_rd = status_word_i;
    if (a == IO_READ_RX) last_rd = rx_data_i;
    if (a == IO_WRITE_TX) last_tx = named_target_register_i;
    iq.push_back({a, last_rd, last_tx});
    @(posedge clk_i);
    #2;
  endtask
  // register write; strobe left high until the next read
  task automatic wr(input logic [4:0] i, input op_size_t s, input logic b, input logic [31:0] d);
    reg_wr_i = 1'b1;
    rd_req = 1'b0;
    reg_wr_idx_i = i;
    size_i = s;
    byte_instr_i = b;
    reg_wr_data_i = d;
    @(posedge clk_i);
    #2;
  endtask
  // register read; its answer is noted for the operand monitor
  task automatic rd(input logic [4:0] i, input op_size_t s, input logic b,
    input logic [31:0] d, input logic n, input logic er);
    reg_wr_i = 1'b0;
    rd_req = 1'b1;
    reg_rd_idx_i = i;
    size_i = s;
    byte_instr_i = b;
    rq.push_back({er, n, d});
    @(posedge clk_i);
    #2;
  endtask

  // ---------------------------------------------------------------
  // monitors and closing
  // ---------------------------------------------------------------
  // macro answers against the oldest note
  always @(negedge clk_i)
    if (macro_o.valid === 1'b1)
    begin
      m = (mq.size() > 0) ? mq.pop_front() : 33'h0ffff0000;
      `CHK("macro_invalid", m[32], macro_o.invalid)
      `CHK("macro_addr", m[31:16], macro_o.addr)
      `CHK("original_word", m[15:0], fetch_original_instruction_o)
    end
  // I/O answers against the oldest note
  always @(negedge clk_i)
    if (io_action_o !== IO_NONE)
    begin
      q = (iq.size() > 0) ? iq.pop_front() : 35'h0;
      `CHK("io_action", q[34:32], io_action_o)
      `CHK("io_read_data", q[31:16], io_read_data_o)
      `CHK("tx_buffer", q[15:0], uart_transmit_buffer_o)
      `CHK("tx_load", q[34:32] == IO_WRITE_TX, tx_load_o)
    end
  // operand answer stands one cycle after each read request
  always @(posedge clk_i)
    rd_due <= rd_req;
  always @(negedge clk_i)
    if (rd_due)
    begin
      r = (rq.size() > 0) ? rq.pop_front() : 34'h0;
      `CHK("size_error", r[33], size_error_o)
      if (!r[33])
      begin
        `CHK("operand", r[31:0], operand_o)
        `CHK("negative", r[32], operand_negative_o)
      end
    end
  task automatic test_done;
    `CHK("notes_left", 0, mq.size() + iq.size() + rq.size())
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // clock and watchdog of about 6000 cycles
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial
  begin
    #150000;
    n_fail++;
    test_done();
  end

  // main sequence
  initial
  begin
    {nrst_i, io_cmd_valid_i, reg_wr_i, byte_instr_i, io_cmd_i, reg_wr_idx_i} = '0;
    {named_target_register_i, status_word_i, rx_data_i, reg_rd_idx_i, reg_wr_data_i} = '0;
    size_i = SIZE_WORD;
    void'($urandom(32'h3b9ab58b));
    repeat (2) @(posedge clk_i);
    #2;
    nrst_i = 1'b1;
    for (int k = 0; k < 256; k++) send({k[7:0], 8'($urandom)});
    for (int k = 0; k < 16; k++) send({8'h4a, 4'($urandom), k[3:0]});
    for (int k = 0; k < 10; k++) send(16'h4400 + 16'h0100 * k[15:0]);
    for (int k = 0; k < 800 && fsm.words.size() > 0; k++) @(posedge clk_i);
    fsm.slow = 1'b1;
    repeat (40) send(16'($urandom));
    for (int k = 0; k < 800 && fsm.words.size() > 0; k++) @(posedge clk_i);
    #2;
    foreach (cmds[i]) io(cmds[i]);
    io_cmd_valid_i = 1'b0;
    wr(5'd3, SIZE_LONG, 1'b0, 32'h82345678);
    rd(5'd2, SIZE_LONG, 1'b0, 32'h82345678, 1'b1, 1'b0);
    rd(5'd2, SIZE_WORD, 1'b0, 32'h00008234, 1'b1, 1'b0);
    rd(5'd3, SIZE_WORD, 1'b0, 32'h00005678, 1'b0, 1'b0);
    wr(5'd19, SIZE_BYTE, 1'b1, 32'h123456a5);
    wr(5'd8, SIZE_WORD, 1'b0, 32'h00007111);
    wr(5'd8, SIZE_BYTE, 1'b0, 32'h00000022);
    rd(5'd19, SIZE_BYTE, 1'b1, 32'h000000a5, 1'b1, 1'b0);
    rd(5'd8, SIZE_WORD, 1'b0, 32'h00007111, 1'b0, 1'b0);
    rd(5'd8, SIZE_WORD, 1'b1, 32'h0, 1'b0, 1'b1);
    rd_req = 1'b0;
    repeat (3) @(posedge clk_i);
    test_done();
  end
endmodule
